// [src/cvs_regs.vh]
// Purpose: constants for the contact value sender
// Assumes: 10 MHz system clock, APB register access
// Notes: offsets are byte addresses of 32-bit words
`ifndef CVS_REGS_VH
`define CVS_REGS_VH

// register offsets
`define CVS_OFS_CTRL      8'h00
`define CVS_OFS_MIN_CLOSE 8'h04
`define CVS_OFS_MIN_OPEN  8'h08
`define CVS_OFS_LONG_T    8'h0c
`define CVS_OFS_WAIT_S    8'h10
`define CVS_OFS_EV0_CFG   8'h14
`define CVS_OFS_EV0_VAL   8'h18
`define CVS_OFS_EV1_CFG   8'h1c
`define CVS_OFS_EV1_VAL   8'h20
`define CVS_OFS_STATUS    8'h24

// control fields
`define CVS_CTRL_SCAN   0
`define CVS_CTRL_MIN    1
`define CVS_CTRL_SL     2
`define CVS_CTRL_OPEN   3
`define CVS_CTRL_BLKEN  4
`define CVS_CTRL_RESTART 8
`define CVS_CTRL_W      5
`define CVS_CTRL_RST    5'h00

// event config fields: type in [3:0], scene store flag in bit 4
`define CVS_CFG_STORE   4
`define CVS_CFG_W       5
`define CVS_CFG_RST     5'h00

// data types
`define CVS_T_NONE  4'h0
`define CVS_T_B1    4'h1
`define CVS_T_B2    4'h2
`define CVS_T_S8    4'h3
`define CVS_T_U8    4'h4
`define CVS_T_SCENE 4'h5
`define CVS_T_S16   4'h6
`define CVS_T_U16   4'h7
`define CVS_T_F16   4'h8
`define CVS_T_TIME  4'h9
`define CVS_T_S32   4'ha
`define CVS_T_U32   4'hb

// time-of-day and scene number limits for fields of the value word
`define CVS_HOUR_MAX 5'h17
`define CVS_MS_MAX   6'h3b
`define CVS_SCENE_MAX 6'h3f

// timing reset values and limits, in tenths of a second / seconds
`define CVS_MIN_RST  16'h000a
`define CVS_LONG_RST 7'h06
`define CVS_LONG_MIN 7'h03
`define CVS_LONG_MAX 7'h64
`define CVS_WAIT_RST 15'h0000
`define CVS_WAIT_MAX 15'h7530

// time base
`define CVS_CLK_HZ   10000000
`define CVS_TICK_MS  100
`define CVS_TICKS_PER_S 4'ha

// object numbering: block of ten per input, first at ten
`define CVS_OBJ_STEP  7'h0a
`define CVS_OBJ_BLOCK 7'h00
`define CVS_OBJ_VAL1  7'h01
`define CVS_OBJ_VAL2  7'h02

`endif

// [src/cvs_contact_sender.v]
// Purpose: one contact input in value/forced-operation mode
// Assumes: contact and bus pulses synchronous to sys_clk_i
// Notes: telegrams leave on a valid/ready port; registers on APB
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "cvs_regs.vh"

// What this block does
// - accept edge only if stable for minimum time
// - new edge restarts minimum time, per direction
// - scan input on restarts only when enabled
// - wait 0..30000 s after bus return
// - after wait treat state as just changed
// - wait is separate from any send delay
// - opening is event 0, closing event 1
// - per-event data type selects telegram format
// - constant limited to its type's range
// - forced value: control high, state low bit
// - scene number 1 to 64 sent
// - scene telegram carries recall or store flag
// - hour 0..23, minute and second 0..59
// - weekday 0 none, 1 Monday..7 Sunday
// - event 1 configured independently like event 0
// - contact type chooses closing or opening actuation
// - long after threshold 0.3..10 s, default 0.6
// - ten object numbers per input from ten
// - block object: 1 disables, 0 enables input
// - blocked: ignore changes, suspend minimum and long timing; wait after bus return runs on
// - blocked: telegrams still sent when due
// - block during scene operation sends store
// - unblock with changed state processes at once
// - manual input unaffected by block
module cvs_contact_sender #(
  parameter INPUT_IDX = 0,
  parameter TICK_CYC = `CVS_CLK_HZ / 1000 * `CVS_TICK_MS
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire contact_i,
  input wire manual_act_i,
  input wire manual_state_i,
  input wire blk_wr_i,
  input wire blk_val_i,
  input wire bus_recov_i,
  input wire download_i,
  output reg tx_valid_o,
  input wire tx_ready_i,
  output reg [6:0] tx_obj_o,
  output reg [2:0] tx_len_o,
  output reg [31:0] tx_data_o
);

  localparam S_IDLE = 6'h01;
  localparam S_WAIT = 6'h02;
  localparam S_MIN = 6'h04;
  localparam S_LONG = 6'h08;
  localparam S_SEND = 6'h10;
  localparam S_HOLD = 6'h20;

  localparam [31:0] OBJ_BASE_W = `CVS_OBJ_STEP * (INPUT_IDX + 1);
  localparam [6:0] OBJ_BASE = OBJ_BASE_W[6:0];

  reg [`CVS_CTRL_W-1:0] ctrl_q;
  reg [15:0] min_close_q;
  reg [15:0] min_open_q;
  reg [6:0] long_q;
  reg [14:0] wait_q;
  reg [`CVS_CFG_W-1:0] cfg0_q;
  reg [`CVS_CFG_W-1:0] cfg1_q;
  reg [31:0] val0_q;
  reg [31:0] val1_q;

  reg [5:0] st_q;
  reg lvl_q;
  reg cand_q;
  reg blk_q;
  reg [18:0] tmr_q;
  reg [31:0] pre_q;
  reg restart_q;

  wire wr_acc = psel_i & penable_i & pwrite_i;
  wire rd_setup = psel_i & ~penable_i & ~pwrite_i;
  reg mapped;

  wire in_lvl = manual_act_i ? manual_state_i : contact_i;
  // block object only acts when enabled
  wire blocked = blk_q & ctrl_q[`CVS_CTRL_BLKEN] & ~manual_act_i;
  wire tick = (pre_q == TICK_CYC - 1);
  wire tmr_done = (tmr_q == 19'h00000);
  wire sl_en = ctrl_q[`CVS_CTRL_SL];
  wire actuated = cand_q ^ ctrl_q[`CVS_CTRL_OPEN];

  // builds {length in bytes, payload} for one event reaction
  function [34:0] fmt;
    input [`CVS_CFG_W-1:0] cfg;
    input [31:0] v;
    input force_store;
    reg [4:0] hr;
    reg [5:0] mi;
    reg [5:0] se;
    reg [5:0] sc;
    begin
      hr = (v[20:16] > `CVS_HOUR_MAX) ? `CVS_HOUR_MAX : v[20:16];
      mi = (v[13:8] > `CVS_MS_MAX) ? `CVS_MS_MAX : v[13:8];
      se = (v[5:0] > `CVS_MS_MAX) ? `CVS_MS_MAX : v[5:0];
      // scene numbers 1..64 travel as 0..63
      sc = (v[6:0] == 7'h00) ? 6'h00 :
           (v[6:0] > {1'b0, `CVS_SCENE_MAX} + 7'h01) ? `CVS_SCENE_MAX :
           (v[5:0] - 6'h01);
      case (cfg[3:0])
        `CVS_T_B1: fmt = {3'h0, 31'h0, v[0]};
        `CVS_T_B2: fmt = {3'h0, 30'h0, v[1:0]};
        `CVS_T_S8, `CVS_T_U8: fmt = {3'h1, 24'h0, v[7:0]};
        `CVS_T_SCENE: fmt = {3'h1, 24'h0,
          cfg[`CVS_CFG_STORE] | force_store, 1'b0, sc};
        `CVS_T_S16, `CVS_T_U16, `CVS_T_F16:
          fmt = {3'h2, 16'h0, v[15:0]};
        `CVS_T_TIME: fmt = {3'h3, 8'h0, v[23:21], hr,
          2'b00, mi, 2'b00, se};
        `CVS_T_S32, `CVS_T_U32: fmt = {3'h4, v};
        default: fmt = {3'h7, 32'h0};
      endcase
    end
  endfunction

  // length 7 marks "do not send"
  wire [34:0] f0 = fmt(cfg0_q, val0_q, 1'b0);
  wire [34:0] f1 = fmt(cfg1_q, val1_q, 1'b0);
  wire [34:0] f1s = fmt(cfg1_q, val1_q, 1'b1);
  wire [34:0] f0s = fmt(cfg0_q, val0_q, 1'b1);

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  always @* begin
    case (paddr_i)
      `CVS_OFS_CTRL, `CVS_OFS_MIN_CLOSE, `CVS_OFS_MIN_OPEN,
      `CVS_OFS_LONG_T, `CVS_OFS_WAIT_S, `CVS_OFS_EV0_CFG,
      `CVS_OFS_EV0_VAL, `CVS_OFS_EV1_CFG, `CVS_OFS_EV1_VAL,
      `CVS_OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // read data is captured in the setup cycle so pready can stay high
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0;
    end else if (rd_setup) begin
      case (paddr_i)
        `CVS_OFS_CTRL: prdata_o <= {27'h0, ctrl_q};
        `CVS_OFS_MIN_CLOSE: prdata_o <= {16'h0, min_close_q};
        `CVS_OFS_MIN_OPEN: prdata_o <= {16'h0, min_open_q};
        `CVS_OFS_LONG_T: prdata_o <= {25'h0, long_q};
        `CVS_OFS_WAIT_S: prdata_o <= {17'h0, wait_q};
        `CVS_OFS_EV0_CFG: prdata_o <= {27'h0, cfg0_q};
        `CVS_OFS_EV0_VAL: prdata_o <= val0_q;
        `CVS_OFS_EV1_CFG: prdata_o <= {27'h0, cfg1_q};
        `CVS_OFS_EV1_VAL: prdata_o <= val1_q;
        `CVS_OFS_STATUS: prdata_o <= {20'h0, st_q, 2'b00,
          blocked, cand_q, in_lvl, lvl_q};
        default: prdata_o <= 32'h0;
      endcase
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_q <= `CVS_CTRL_RST;
      min_close_q <= `CVS_MIN_RST;
      min_open_q <= `CVS_MIN_RST;
      long_q <= `CVS_LONG_RST;
      wait_q <= `CVS_WAIT_RST;
      cfg0_q <= `CVS_CFG_RST;
      cfg1_q <= `CVS_CFG_RST;
      val0_q <= 32'h0;
      val1_q <= 32'h0;
      restart_q <= 1'b0;
    end else begin
      // a configuration reset acts like a fresh download
      restart_q <= wr_acc & (paddr_i == `CVS_OFS_CTRL) &
                   pwdata_i[`CVS_CTRL_RESTART];
      if (wr_acc) begin
        case (paddr_i)
          `CVS_OFS_CTRL: ctrl_q <= pwdata_i[`CVS_CTRL_W-1:0];
          `CVS_OFS_MIN_CLOSE: min_close_q <= pwdata_i[15:0];
          `CVS_OFS_MIN_OPEN: min_open_q <= pwdata_i[15:0];
          `CVS_OFS_LONG_T: begin
            if (pwdata_i[6:0] < `CVS_LONG_MIN) begin
              long_q <= `CVS_LONG_MIN;
            end else if (pwdata_i[31:7] != 25'h0 ||
                         pwdata_i[6:0] > `CVS_LONG_MAX) begin
              long_q <= `CVS_LONG_MAX;
            end else begin
              long_q <= pwdata_i[6:0];
            end
          end
          `CVS_OFS_WAIT_S: wait_q <= (pwdata_i[14:0] > `CVS_WAIT_MAX) ?
                                      `CVS_WAIT_MAX : pwdata_i[14:0];
          `CVS_OFS_EV0_CFG: cfg0_q <= pwdata_i[`CVS_CFG_W-1:0];
          `CVS_OFS_EV0_VAL: val0_q <= pwdata_i;
          `CVS_OFS_EV1_CFG: cfg1_q <= pwdata_i[`CVS_CFG_W-1:0];
          `CVS_OFS_EV1_VAL: val1_q <= pwdata_i;
          default: ;
        endcase
      end
    end
  end

  // queue one telegram unless its type is "do not send"
  task send;
    input [34:0] f;
    input [6:0] ofs;
    begin
      if (f[34:32] != 3'h7) begin
        tx_valid_o <= 1'b1;
        tx_obj_o <= OBJ_BASE + ofs;
        tx_len_o <= f[34:32];
        tx_data_o <= f[31:0];
        st_q <= S_SEND;
      end else begin
        st_q <= S_IDLE;
      end
    end
  endtask

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      lvl_q <= 1'b0;
      cand_q <= 1'b0;
      blk_q <= 1'b0;
      tmr_q <= 19'h0;
      pre_q <= 32'h0;
      tx_valid_o <= 1'b0;
      tx_obj_o <= 7'h0;
      tx_len_o <= 3'h0;
      tx_data_o <= 32'h0;
    end else begin
      if (blk_wr_i) begin
        blk_q <= blk_val_i;
      end
      if (!blocked || st_q == S_WAIT) begin
        pre_q <= tick ? 32'h0 : pre_q + 32'h1;
        if (tick && !tmr_done) begin
          tmr_q <= tmr_q - 19'h1;
        end
      end
      if (bus_recov_i || download_i || restart_q) begin
        tx_valid_o <= 1'b0;
        pre_q <= 32'h0;
        if (!ctrl_q[`CVS_CTRL_SCAN]) begin
          lvl_q <= in_lvl;
          cand_q <= in_lvl;
          st_q <= S_IDLE;
        end else if (bus_recov_i) begin
          // own wait, no send delay added
          tmr_q <= {wait_q, 3'b000} + {3'b000, wait_q, 1'b0};
          st_q <= S_WAIT;
        end else begin
          lvl_q <= ~in_lvl;
          st_q <= S_IDLE;
        end
      end else begin
        case (st_q)
          S_WAIT: begin
            if (tmr_done) begin
              // force a difference so it looks like a change
              lvl_q <= ~in_lvl;
              st_q <= S_IDLE;
            end
          end
          S_IDLE, S_HOLD: begin
            if (!blocked && in_lvl != lvl_q) begin
              cand_q <= in_lvl;
              pre_q <= 32'h0;
              if (ctrl_q[`CVS_CTRL_MIN]) begin
                tmr_q <= {3'b000, in_lvl ? min_close_q : min_open_q};
                st_q <= S_MIN;
              end else begin
                lvl_q <= in_lvl;
                if (sl_en) begin
                  if (in_lvl ^ ctrl_q[`CVS_CTRL_OPEN]) begin
                    tmr_q <= {12'h0, long_q};
                    st_q <= S_LONG;
                  end else begin
                    st_q <= S_IDLE;
                  end
                end else if (in_lvl) begin
                  send(f1, `CVS_OBJ_VAL2);
                end else begin
                  send(f0, `CVS_OBJ_VAL1);
                end
              end
            end
          end
          S_MIN: begin
            if (!blocked) begin
              if (in_lvl != cand_q) begin
                cand_q <= in_lvl;
                pre_q <= 32'h0;
                tmr_q <= {3'b000, in_lvl ? min_close_q : min_open_q};
              end else if (tmr_done) begin
                lvl_q <= cand_q;
                if (sl_en) begin
                  if (actuated) begin
                    pre_q <= 32'h0;
                    tmr_q <= {12'h0, long_q};
                    st_q <= S_LONG;
                  end else begin
                    st_q <= S_IDLE;
                  end
                end else if (cand_q) begin
                  // closing event 1, opening event 0
                  send(f1, `CVS_OBJ_VAL2);
                end else begin
                  send(f0, `CVS_OBJ_VAL1);
                end
              end
            end
          end
          S_LONG: begin
            if (blocked) begin
              // end a pending scene operation by storing
              if (cfg1_q[3:0] == `CVS_T_SCENE) begin
                send(f1s, `CVS_OBJ_VAL2);
              end else if (cfg0_q[3:0] == `CVS_T_SCENE) begin
                send(f0s, `CVS_OBJ_VAL1);
              end
            end else if (in_lvl != lvl_q) begin
              lvl_q <= in_lvl;
              cand_q <= in_lvl;
              send(f0, `CVS_OBJ_VAL1);
            end else if (tmr_done) begin
              send(f1, `CVS_OBJ_VAL2);
            end
          end
          S_SEND: begin
            // delivery does not depend on the block
            if (tx_ready_i) begin
              tx_valid_o <= 1'b0;
              st_q <= S_HOLD;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

endmodule // cvs_contact_sender

// [test/cvs_monitor.sv]
// Purpose: port checker for the contact value sender
// Assumes: sees only the top ports, INPUT_IDX as bound
// Notes: bind statement follows the module
`timescale 1ns/100ps
module cvs_monitor #(
  parameter INPUT_IDX = 0
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire [7:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pslverr_o,
  input wire tx_valid_o,
  input wire tx_ready_i,
  input wire [6:0] tx_obj_o,
  input wire [2:0] tx_len_o,
  input wire [31:0] tx_data_o
);
  localparam [6:0] BASE = 7'h0a * (INPUT_IDX + 1);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire acc = psel_i && penable_i;
  wire unm = paddr_i > 8'h24 || paddr_i[1:0] != 2'b00;
  wire stl = tx_valid_o && !tx_ready_i;
  property p_err; acc |-> pslverr_o == unm; endproperty
  a_err: assert property (p_err) else $error("slverr wrong");
  property p_hold; stl |=> tx_valid_o && $stable(tx_data_o)
    && $stable(tx_obj_o) && $stable(tx_len_o); endproperty
  a_hold: assert property (p_hold) else $error("telegram moved");
  property p_drop; tx_valid_o && tx_ready_i |=> !tx_valid_o; endproperty
  a_drop: assert property (p_drop) else $error("telegram repeated");
  property p_obj; tx_valid_o |-> tx_obj_o == BASE + 7'h01
    || tx_obj_o == BASE + 7'h02; endproperty
  a_obj: assert property (p_obj) else $error("bad object");
  property p_len; tx_valid_o |-> tx_len_o <= 3'h4; endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_fit; tx_valid_o && tx_len_o != 3'h4 |-> (tx_data_o >>
    (tx_len_o == 3'h0 ? 2 : 8 * tx_len_o)) == 32'h0; endproperty
  a_fit: assert property (p_fit) else $error("data too wide");
  property p_tod; tx_valid_o && tx_len_o == 3'h3 |-> tx_data_o[20:16]
    <= 5'h17 && tx_data_o[13:8] <= 6'h3b && tx_data_o[5:0] <= 6'h3b;
  endproperty
  a_tod: assert property (p_tod) else $error("bad time");
  property p_rst; disable iff (1'b0) rst_i |=> !tx_valid_o
    && prdata_o == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_take: cover property (tx_valid_o && tx_ready_i);
  c_stall: cover property (stl [*3]);
  c_err: cover property (acc && pslverr_o);
endmodule // cvs_monitor

bind cvs_contact_sender cvs_monitor #(.INPUT_IDX(INPUT_IDX)) u_mon (
  .sys_clk_i, .rst_i, .psel_i, .penable_i, .paddr_i, .prdata_o,
  .pslverr_o, .tx_valid_o, .tx_ready_i, .tx_obj_o, .tx_len_o,
  .tx_data_o);

// [test/cvs_bus_model.sv]
// Purpose: bus side partner, takes telegrams and writes block
// Assumes: stall_i sets the wait before ready
// Notes: ready is never offered before valid is seen
`timescale 1ns/100ps
module cvs_bus_model (
  input wire sys_clk_i,
  input wire rst_i,
  input wire tx_valid_i,
  input wire [6:0] tx_obj_i,
  input wire [2:0] tx_len_i,
  input wire [31:0] tx_data_i,
  input wire [3:0] stall_i,
  output reg tx_ready_o = 1'b0,
  output reg blk_wr_o = 1'b0,
  output reg blk_val_o = 1'b1
);
  integer tg_cnt = 0;
  reg [6:0] obj_q;
  reg [2:0] len_q;
  reg [31:0] data_q;
  reg [3:0] wait_q = 4'h0;
  always @(posedge sys_clk_i) begin
    if (rst_i || !tx_valid_i) begin
      tx_ready_o <= 1'b0;
      wait_q <= 4'h0;
    end else if (tx_ready_o) begin
      tg_cnt <= tg_cnt + 1;
      obj_q <= tx_obj_i;
      len_q <= tx_len_i;
      data_q <= tx_data_i;
      tx_ready_o <= 1'b0;
    end else if (wait_q >= stall_i) begin
      tx_ready_o <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
  task write_block(input v);
    begin
      @(posedge sys_clk_i);
      blk_wr_o <= 1'b1;
      blk_val_o <= v;
      @(posedge sys_clk_i);
      blk_wr_o <= 1'b0;
      // value is meaningless once the write pulse ends
      blk_val_o <= ~v;
    end
  endtask
endmodule // cvs_bus_model

// [test/tb_top.sv]
// Purpose: self-checking bench for the contact value sender
// Assumes: tick shortened to 10 cycles, input index 0
// Notes: bus side answers through cvs_bus_model
`timescale 1ns/100ps
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0;
  reg pen = 1'b0;
  reg pwr = 1'b0;
  reg con = 1'b0;
  reg mact = 1'b0;
  reg mst = 1'b0;
  reg brec = 1'b0;
  reg dl = 1'b0;
  reg [7:0] pa = 8'h00;
  reg [31:0] pwd = 32'h0;
  reg [3:0] stall = 4'h0;
  wire [31:0] prd;
  wire [31:0] dat;
  wire [6:0] obj;
  wire [2:0] len;
  wire prdy, perr, tv, tr, bw, bv;
  integer error_cnt = 0;
  integer n_checks = 0;
  integer c0;
  cvs_contact_sender #(.INPUT_IDX(0), .TICK_CYC(10)) u_dut (
    .sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .contact_i(con),
    .manual_act_i(mact), .manual_state_i(mst), .blk_wr_i(bw),
    .blk_val_i(bv), .bus_recov_i(brec), .download_i(dl),
    .tx_valid_o(tv), .tx_ready_i(tr), .tx_obj_o(obj),
    .tx_len_o(len), .tx_data_o(dat));
  cvs_bus_model u_bus (.sys_clk_i(clk), .rst_i(rst), .tx_valid_i(tv),
    .tx_obj_i(obj), .tx_len_i(len), .tx_data_i(dat), .stall_i(stall),
    .tx_ready_o(tr), .blk_wr_o(bw), .blk_val_o(bv));
  initial forever #50 clk = ~clk;
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d, output [31:0] r,
           output e);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (prdy !== 1'b1) @(posedge clk);
      r = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] r;
    reg e;
    begin
      apb(1'b1, a, d, r, e);
    end
  endtask
  task rd(input [7:0] a, input [31:0] x, input ex);
    reg [31:0] r;
    reg e;
    begin
      apb(1'b0, a, 32'h0, r, e);
      chk("reg", x, r);
      chk("slverr", {31'h0, ex}, {31'h0, e});
    end
  endtask
  task do_rst;
    begin
      @(posedge clk);
      rst <= 1'b1;
      con <= 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
    end
  endtask
  task et(input [6:0] o, input [2:0] l, input [31:0] d, input integer m);
    begin
      c0 = u_bus.tg_cnt;
      while (u_bus.tg_cnt == c0 && m > 0) begin
        @(posedge clk);
        m = m - 1;
      end
      chk("count", 1, u_bus.tg_cnt - c0);
      // zero means any of the two value objects
      if (o != 7'h00) chk("object", {25'h0, o}, {25'h0, u_bus.obj_q});
      chk("length", {29'h0, l}, {29'h0, u_bus.len_q});
      chk("data", d, u_bus.data_q);
    end
  endtask
  task nt(input integer n);
    begin
      c0 = u_bus.tg_cnt;
      repeat (n) @(posedge clk);
      chk("silence", 0, u_bus.tg_cnt - c0);
    end
  endtask
  task pls(input d);
    begin
      @(posedge clk);
      if (d) dl <= 1'b1;
      else brec <= 1'b1;
      @(posedge clk);
      dl <= 1'b0;
      brec <= 1'b0;
    end
  endtask
  task cfg_u8;
    begin
      wr(8'h14, 32'h4);
      wr(8'h18, 32'h11);
      wr(8'h1c, 32'h4);
      wr(8'h20, 32'h22);
    end
  endtask
  task t_regs;
    begin
      rd(8'h00, 32'h0, 1'b0);
      rd(8'h24, 32'h40, 1'b0);
      rd(8'h04, 32'h0a, 1'b0);
      rd(8'h08, 32'h0a, 1'b0);
      rd(8'h0c, 32'h06, 1'b0);
      rd(8'h28, 32'h0, 1'b1);
      wr(8'h0c, 32'h65);
      rd(8'h0c, 32'h64, 1'b0);
      wr(8'h0c, 32'h02);
      rd(8'h0c, 32'h03, 1'b0);
      wr(8'h10, 32'h7531);
      rd(8'h10, 32'h7530, 1'b0);
      @(posedge clk) con <= 1'b1;
      nt(20);
      rd(8'h24, 32'h47, 1'b0);
    end
  endtask
  task one_type(input [4:0] cf, input [31:0] v, input [2:0] l,
                input [31:0] x);
    begin
      wr(8'h1c, {27'h0, cf});
      wr(8'h20, v);
      @(posedge clk) con <= 1'b1;
      et(7'h0c, l, x, 30);
      @(posedge clk) con <= 1'b0;
      et(7'h0b, 3'h1, 32'h5a, 30);
    end
  endtask
  task t_types;
    begin
      do_rst;
      stall <= 4'h6;
      wr(8'h14, 32'h4);
      wr(8'h18, 32'h5a);
      one_type(5'h01, 32'h1, 3'h0, 32'h1);
      one_type(5'h02, 32'h2, 3'h0, 32'h2);
      one_type(5'h03, 32'h80, 3'h1, 32'h80);
      one_type(5'h07, 32'hffff, 3'h2, 32'hffff);
      one_type(5'h0a, 32'h80000000, 3'h4, 32'h80000000);
      one_type(5'h15, 32'h40, 3'h1, 32'hbf);
      one_type(5'h05, 32'h01, 3'h1, 32'h00);
      one_type(5'h09, 32'hf73b3a, 3'h3, 32'hf73b3a);
      stall <= 4'h0;
    end
  endtask
  task t_min;
    begin
      do_rst;
      cfg_u8;
      wr(8'h04, 32'h3);
      wr(8'h08, 32'h3);
      wr(8'h00, 32'h2);
      @(posedge clk) con <= 1'b1;
      repeat (5) @(posedge clk);
      con <= 1'b0;
      repeat (5) @(posedge clk);
      con <= 1'b1;
      nt(26);
      et(7'h0c, 3'h1, 32'h22, 30);
    end
  endtask
  task t_block;
    begin
      do_rst;
      cfg_u8;
      wr(8'h00, 32'h10);
      u_bus.write_block(1'b1);
      mact <= 1'b1;
      mst <= 1'b1;
      et(7'h0c, 3'h1, 32'h22, 20);
      mst <= 1'b0;
      et(7'h0b, 3'h1, 32'h11, 20);
      mact <= 1'b0;
      con <= 1'b1;
      nt(30);
      u_bus.write_block(1'b0);
      et(7'h0c, 3'h1, 32'h22, 20);
    end
  endtask
  task t_sl;
    begin
      do_rst;
      cfg_u8;
      wr(8'h00, 32'h1c);
      @(posedge clk) con <= 1'b1;
      nt(15);
      con <= 1'b0;
      repeat (10) @(posedge clk);
      con <= 1'b1;
      et(7'h0b, 3'h1, 32'h11, 20);
      do_rst;
      cfg_u8;
      wr(8'h0c, 32'h3);
      wr(8'h00, 32'h14);
      @(posedge clk) con <= 1'b1;
      repeat (10) @(posedge clk);
      con <= 1'b0;
      et(7'h0b, 3'h1, 32'h11, 20);
      con <= 1'b1;
      nt(15);
      et(7'h0c, 3'h1, 32'h22, 30);
      con <= 1'b0;
      nt(40);
      wr(8'h14, 32'h5);
      wr(8'h18, 32'h3);
      wr(8'h1c, 32'h5);
      wr(8'h20, 32'h3);
      @(posedge clk) con <= 1'b1;
      u_bus.write_block(1'b1);
      et(7'h00, 3'h1, 32'h82, 20);
    end
  endtask
  task t_restart;
    begin
      do_rst;
      cfg_u8;
      wr(8'h10, 32'h1);
      wr(8'h00, 32'h1);
      @(posedge clk) con <= 1'b1;
      et(7'h0c, 3'h1, 32'h22, 20);
      pls(1'b0);
      nt(85);
      et(7'h0c, 3'h1, 32'h22, 40);
      pls(1'b1);
      et(7'h0c, 3'h1, 32'h22, 20);
      wr(8'h00, 32'h101);
      et(7'h0c, 3'h1, 32'h22, 20);
      wr(8'h00, 32'h0);
      pls(1'b0);
      pls(1'b1);
      nt(150);
    end
  endtask
  task test_done;
    begin
      if (error_cnt == 0 && n_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_types;
    t_min;
    t_block;
    t_sl;
    t_restart;
    test_done;
  end
  // whole run is about a thousand cycles, so this only trips on a hang
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt = error_cnt + 1;
    test_done;
  end
endmodule // tb_top
